// ===== design/uart_mode_pkg.sv
// Constants, field layout and carrier types for the serial port mode control block.
// Assumes a single 20 MHz clock domain and an AHB-Lite register slave.
package uart_mode_pkg;

  localparam logic [31:0] MODE_REG_ADDR  = 32'h0000_0000;
  localparam logic [31:0] PIN_STATE_ADDR = 32'h0000_0004;
  localparam logic [15:0] MODE_RESET     = 16'h0000;
  localparam logic [15:0] MODE_WR_MASK   = 16'hbbff;
  localparam int          BIT_ENABLE     = 15;
  localparam int          BIT_HALT_IDLE  = 13;
  localparam int          BIT_IR_ENABLE  = 12;
  localparam int          BIT_RTS_MODE   = 11;
  localparam int          USAGE_LSB      = 8;
  localparam int          BAUD_DIV_RESET = 0;
  localparam int          IR_PULSE_SIXTEENTHS = 3;
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;

  typedef enum logic [1:0] {
    USAGE_TXRX      = 2'b00,
    USAGE_TXRX_RTS  = 2'b01,
    USAGE_ALL_FOUR  = 2'b10,
    USAGE_BAUD_CLK  = 2'b11
  } pin_usage_e;

  typedef struct packed {
    logic       port_module_enable;
    logic       halt_in_idle;
    logic       infrared_codec_enable;
    logic       request_pin_mode;
    pin_usage_e pin_usage_select;
  } mode_ctrl_s;

  typedef struct packed {
    logic tx_owned;
    logic rx_owned;
    logic rts_owned;
    logic cts_owned;
    logic bclk_owned;
  } pin_own_s;

  typedef enum logic [1:0] {
    AHB_IDLE   = 2'b00,
    AHB_NONSEQ = 2'b10
  } htrans_e;

endpackage

// ===== design/uart_pin_owner.sv
// Pin ownership decode from the enable bit and the pin usage field.
// Assumes the mode fields are registered by the caller.
`timescale 1ns/10ps
`default_nettype none
module uart_pin_owner (
  input  wire uart_mode_pkg::mode_ctrl_s ctrl_i,
  output var  uart_mode_pkg::pin_own_s   own_o
);
  import uart_mode_pkg::*;

  always_comb begin
    own_o = '0;
    if (ctrl_i.port_module_enable) begin
      own_o.tx_owned = 1'b1;
      own_o.rx_owned = 1'b1;
      case (ctrl_i.pin_usage_select)
        USAGE_BAUD_CLK: begin
          own_o.bclk_owned = 1'b1;
        end
        USAGE_ALL_FOUR: begin
          own_o.rts_owned = 1'b1;
          own_o.cts_owned = 1'b1;
        end
        USAGE_TXRX_RTS: begin
          own_o.rts_owned = 1'b1;
        end
        default: begin
          own_o.rts_owned = 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== design/uart_ir_codec.sv
// Infrared pulse encoder and decoder working on a 16x baud tick.
// Assumes tick_i is a one-cycle pulse at sixteen times the bit rate.
`timescale 1ns/10ps
`default_nettype none
module uart_ir_codec (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic run_i,
  input  wire logic tick_i,
  input  wire logic tx_bit_i,
  input  wire logic ir_rx_i,
  output logic      ir_tx_o,
  output logic      rx_bit_o
);
  import uart_mode_pkg::*;

  logic [3:0] phase;
  logic       ir_rx_prev;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase <= 4'h0;
    end else if (!run_i) begin
      phase <= 4'h0;
    end else if (tick_i) begin
      phase <= phase + 4'h1;
    end
  end

  // A zero bit is sent as a short high pulse of three sixteenths, a one as no light.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ir_tx_o <= 1'b0;
    end else begin
      ir_tx_o <= run_i && !tx_bit_i && (phase < 4'(IR_PULSE_SIXTEENTHS));
    end
  end

  // Any received pulse pulls the decoded line low for the rest of its bit slot.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ir_rx_prev <= 1'b0;
      rx_bit_o   <= 1'b1;
    end else begin
      ir_rx_prev <= ir_rx_i;
      if (!run_i) begin
        rx_bit_o <= 1'b1;
      end else if (ir_rx_i && !ir_rx_prev) begin
        rx_bit_o <= 1'b0;
      end else if (tick_i && phase == 4'hf) begin
        rx_bit_o <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== design/uart_mode_ctrl.sv
// Serial port mode control: register, pin ownership, infrared codec selection and baud clock pin.
// Assumes an AHB-Lite master, a core that supplies framed bits and a baud divisor and takes the 16x tick, and port latches.
//
// Function
// - Infrared codec active only while bit 12 set; bypassed otherwise.
// - With codec enabled, receive pin is decoded as infrared receiver input.
// - With codec enabled, transmit pin carries encoded infrared pulses.
// - Bit 13 set stops the port in idle; clear keeps running.
// - Bit 11 set gives simplex request pin; clear gives flow control.
// - Usage 11 owns transmit, receive and baud clock; clear-to-send to latches.
// - Usage 10 all four pins; 01 adds request; 00 only transmit/receive.
// - Baud clock pin outputs 16x baud clock when selected and enabled.
`timescale 1ns/10ps
`default_nettype none
module uart_mode_ctrl #(
  parameter int BAUD_DIV_WIDTH = 16
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   hsel_i,
  input  wire logic [31:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic [31:0]                 hrdata_o,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  input  wire logic                   device_idle_i,
  input  wire logic                   core_tx_bit_i,
  input  wire logic                   core_rts_flow_i,
  input  wire logic                   core_tx_busy_i,
  input  wire logic [BAUD_DIV_WIDTH-1:0] baud_div_i,
  input  wire logic                   serial_receive_pin_i,
  input  wire logic                   clear_to_send_pin_i,
  input  wire logic                   latch_tx_i,
  input  wire logic                   latch_rts_i,
  output logic                        core_rx_bit_o,
  output logic                        core_cts_o,
  output logic                        core_run_o,
  output logic                        baud_tick_o,
  output logic                        serial_transmit_pin_o,
  output logic                        request_to_send_pin_o,
  output uart_mode_pkg::pin_own_s     pin_own_o
);
  import uart_mode_pkg::*;

  logic [15:0]               serial_port_mode;
  mode_ctrl_s                ctrl;
  pin_own_s                  own_comb;
  logic                      wr_pend;
  logic [31:0]               wr_addr;
  logic                      run;
  logic [BAUD_DIV_WIDTH-1:0] baud_cnt;
  logic                      tick;
  logic                      bclk_level;
  logic                      ir_tx;
  logic                      ir_rx_bit;
  logic                      ir_run;
  logic                      next_tx;
  logic                      next_rx;
  logic                      next_rts;
  logic [31:0]               next_rdata;

  assign ctrl.port_module_enable    = serial_port_mode[BIT_ENABLE];
  assign ctrl.halt_in_idle          = serial_port_mode[BIT_HALT_IDLE];
  assign ctrl.infrared_codec_enable = serial_port_mode[BIT_IR_ENABLE];
  assign ctrl.request_pin_mode      = serial_port_mode[BIT_RTS_MODE];
  assign ctrl.pin_usage_select      = pin_usage_e'(serial_port_mode[USAGE_LSB+1:USAGE_LSB]);

  // Bus slave: zero wait states, always OKAY, writes land in the data phase.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend <= 1'b0;
    end else if (hready_i) begin
      wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
    end
  end

  // The address is kept for the data phase, when the write data arrive.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_addr <= 32'h0000_0000;
    end else if (hready_i) begin
      wr_addr <= haddr_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_port_mode <= MODE_RESET;
    end else if (wr_pend && wr_addr == MODE_REG_ADDR) begin
      serial_port_mode <= hwdata_i[15:0] & MODE_WR_MASK;
    end
  end

  // Unmapped offsets read as zero, so software can probe without a bus error.
  always_comb begin
    if (haddr_i == MODE_REG_ADDR) begin
      next_rdata = {16'h0000, serial_port_mode};
    end else if (haddr_i == PIN_STATE_ADDR) begin
      next_rdata = {26'h0, run, own_comb};
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // Read data is registered in the address phase so it stands in the data phase.
  // A read issued right behind a write to the same register therefore returns the old value.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      hrdata_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hreadyout_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  // Disabled or idle-halted port stops its clocks, which is where the power goes.
  assign run = ctrl.port_module_enable && !(ctrl.halt_in_idle && device_idle_i);

  uart_pin_owner u_pin_owner (
    .ctrl_i (ctrl),
    .own_o  (own_comb)
  );

  // The 16x tick comes from a divider reloaded whenever the port is not running.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      baud_cnt <= BAUD_DIV_WIDTH'(BAUD_DIV_RESET);
    end else if (!run || baud_cnt >= baud_div_i) begin
      baud_cnt <= BAUD_DIV_WIDTH'(BAUD_DIV_RESET);
    end else begin
      baud_cnt <= baud_cnt + BAUD_DIV_WIDTH'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick <= 1'b0;
    end else begin
      tick <= run && baud_cnt >= baud_div_i;
    end
  end

  // High over the first half of each divider period; at a divisor of zero the period is one cycle and the pin stays high.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bclk_level <= 1'b0;
    end else begin
      bclk_level <= run && baud_cnt <= (baud_div_i >> 1);
    end
  end

  assign ir_run = run && ctrl.infrared_codec_enable;

  uart_ir_codec u_ir_codec (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .run_i    (ir_run),
    .tick_i   (tick),
    .tx_bit_i (core_tx_bit_i),
    .ir_rx_i  (serial_receive_pin_i),
    .ir_tx_o  (ir_tx),
    .rx_bit_o (ir_rx_bit)
  );

  always_comb begin
    if (!own_comb.tx_owned) begin
      next_tx = latch_tx_i;
    end else if (ctrl.infrared_codec_enable) begin
      next_tx = ir_tx;
    end else begin
      next_tx = core_tx_bit_i;
    end
  end

  // An unowned receive pin reads as the idle line level, so the core sees no false start bit.
  always_comb begin
    if (!own_comb.rx_owned) begin
      next_rx = 1'b1;
    end else if (ctrl.infrared_codec_enable) begin
      next_rx = ir_rx_bit;
    end else begin
      next_rx = serial_receive_pin_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_transmit_pin_o <= 1'b1;
    end else begin
      serial_transmit_pin_o <= next_tx;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      core_rx_bit_o <= 1'b1;
    end else begin
      core_rx_bit_o <= next_rx;
    end
  end

  // Clear-to-send is active low; unowned it reads as permission to send.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      core_cts_o <= 1'b0;
    end else begin
      core_cts_o <= own_comb.cts_owned ? clear_to_send_pin_i : 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      core_run_o <= 1'b0;
    end else begin
      core_run_o <= run;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      baud_tick_o <= 1'b0;
    end else begin
      baud_tick_o <= tick;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_own_o <= '0;
    end else begin
      pin_own_o <= own_comb;
    end
  end

  // The request pin doubles as the baud clock pin; simplex drives it low while sending.
  always_comb begin
    if (own_comb.bclk_owned) begin
      next_rts = bclk_level;
    end else if (!own_comb.rts_owned) begin
      next_rts = latch_rts_i;
    end else if (ctrl.request_pin_mode) begin
      next_rts = !core_tx_busy_i;
    end else begin
      next_rts = core_rts_flow_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      request_to_send_pin_o <= 1'b1;
    end else begin
      request_to_send_pin_o <= next_rts;
    end
  end

endmodule
`default_nettype wire

// ===== tb/uart_mode_ctrl_chk.sv
// Assertion checker for the serial port mode control block.
// Assumes it is bound to uart_mode_ctrl and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module uart_mode_ctrl_chk (
  input wire logic                    clk_i,
  input wire logic                    rst_b_i,
  input wire logic                    hsel_i,
  input wire logic [31:0]             haddr_i,
  input wire logic [1:0]              htrans_i,
  input wire logic                    hwrite_i,
  input wire logic                    hready_i,
  input wire logic [31:0]             hrdata_o,
  input wire logic                    hreadyout_o,
  input wire logic                    hresp_o,
  input wire logic                    core_rx_bit_o,
  input wire logic                    core_cts_o,
  input wire logic                    core_run_o,
  input wire uart_mode_pkg::pin_own_s pin_own_o
);
  import uart_mode_pkg::*;
  logic rd_bad;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  assign rd_bad = hsel_i & hready_i & htrans_i[1] & !hwrite_i & (haddr_i[31:3] != 29'h0);
  property p_okay; hresp_o == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_ready; $past(rst_b_i) |-> hreadyout_o; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_unmapped; rd_bad |=> hrdata_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pair; pin_own_o.tx_owned == pin_own_o.rx_owned; endproperty
  a_pair: assert property (p_pair) else $error("transmit and receive ownership differ");
  property p_off; !pin_own_o.tx_owned |-> pin_own_o == 5'h0; endproperty
  a_off: assert property (p_off) else $error("pin owned while port off");
  property p_run; core_run_o |-> pin_own_o.tx_owned; endproperty
  a_run: assert property (p_run) else $error("running without pins");
  property p_cts; pin_own_o.cts_owned |-> pin_own_o.rts_owned && !pin_own_o.bclk_owned; endproperty
  a_cts: assert property (p_cts) else $error("clear-to-send owned alone");
  property p_bclk; pin_own_o.bclk_owned |-> !pin_own_o.rts_owned; endproperty
  a_bclk: assert property (p_bclk) else $error("baud clock and request both owned");
  property p_cts_off; !pin_own_o.cts_owned [*2] |-> !core_cts_o; endproperty
  a_cts_off: assert property (p_cts_off) else $error("unowned clear-to-send not asserted");
  property p_rx_idle; !pin_own_o.rx_owned [*2] |-> core_rx_bit_o; endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("unowned receive not idle");
  c_bclk: cover property (pin_own_o.bclk_owned);
  c_cts: cover property (pin_own_o.cts_owned);
  c_unm: cover property (rd_bad);
endmodule
bind uart_mode_ctrl uart_mode_ctrl_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .core_rx_bit_o(core_rx_bit_o), .core_cts_o(core_cts_o), .core_run_o(core_run_o),
  .pin_own_o(pin_own_o));
`default_nettype wire

// ===== tb/ir_loop_peer.sv
// Far-side peer: an infrared transceiver whose light falls back on its own receiver.
// Assumes the transmit pin is seen on the block's 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module ir_loop_peer (
  input  wire logic clk_i,
  input  wire logic tx_pin_i,
  input  wire logic cts_level_i,
  output logic      rx_pin_o,
  output logic      cts_pin_o
);
  // The path adds one cycle, so the receiver never sees a pulse in the cycle it is sent.
  initial begin
    {rx_pin_o, cts_pin_o} = 2'b11;
    forever begin
      @(posedge clk_i);
      rx_pin_o  <= tx_pin_i;
      cts_pin_o <= cts_level_i;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_uart_mode_ctrl.sv
// Self-checking testbench for the serial port mode control block.
// Assumes a 20 MHz clock, this bench as the only AHB-Lite master and a looped infrared peer.
`timescale 1ns/10ps
`default_nettype none
module tb_uart_mode_ctrl;
  import uart_mode_pkg::*;
  logic        clk, rst_b, hsel, hwrite, idle, tx_bit, rts_flow, tx_busy, lat_tx, lat_rts, cts_lvl;
  logic        rx_pin, cts_pin, hready, hresp, rx_bit, cts, run, tick, tx_pin, rts_pin;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] div;
  logic [31:0] haddr, hwdata, hrdata, rd, rnd;
  pin_own_s    own;
  int          n_mismatch, cmp_count, cnt, i;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  uart_mode_ctrl u_dut (.clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .device_idle_i(idle), .core_tx_bit_i(tx_bit),
    .core_rts_flow_i(rts_flow), .core_tx_busy_i(tx_busy), .baud_div_i(div), .serial_receive_pin_i(rx_pin),
    .clear_to_send_pin_i(cts_pin), .latch_tx_i(lat_tx), .latch_rts_i(lat_rts), .core_rx_bit_o(rx_bit),
    .core_cts_o(cts), .core_run_o(run), .baud_tick_o(tick), .serial_transmit_pin_o(tx_pin),
    .request_to_send_pin_o(rts_pin), .pin_own_o(own));
  ir_loop_peer u_peer (.clk_i(clk), .tx_pin_i(tx_pin), .cts_level_i(cts_lvl), .rx_pin_o(rx_pin),
    .cts_pin_o(cts_pin));
  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic edge_ready();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    {hsel, htrans, haddr, hwrite} <= {1'b1, AHB_NONSEQ, a, wr};
    edge_ready();
    {hsel, htrans, hwdata} <= {1'b0, AHB_IDLE, wd};
    edge_ready();
    rd = hrdata;
  endtask
  // A read launched at the very edge that ends a write still returns the old value; the three spare edges also let the registered pins settle.
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
    repeat (3) @(posedge clk);
  endtask
  task automatic count(input int which, input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge clk);
      case (which)
        0: cnt += int'(tx_pin === 1'b1);
        1: cnt += int'(rx_bit === 1'b0);
        2: cnt += int'(tick === 1'b1);
        default: cnt += int'(rts_pin === 1'b1);
      endcase
    end
  endtask
  function automatic logic [4:0] exp_own(input logic [1:0] u);
    return {2'b11, u == 2'b01 || u == 2'b10, u == 2'b10, u == 2'b11};
  endfunction
  initial begin
    {rst_b, hsel, hwrite, idle, tx_bit, rts_flow, tx_busy, lat_tx, lat_rts, cts_lvl} = 10'h0;
    {htrans, hsize, div, haddr, hwdata} = {AHB_IDLE, 3'h2, 16'h3, 64'h0};
    n_mismatch = 0;
    cmp_count = 0;
    void'($urandom(21275));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, MODE_REG_ADDR, 32'h0);
    chk(rd, {16'h0, MODE_RESET});
    for (i = 0; i < 6; i++) begin
      rnd = $urandom();
      wr(MODE_REG_ADDR, rnd);
      bus(1'b0, MODE_REG_ADDR, 32'h0);
      chk(rd, rnd & {16'h0, MODE_WR_MASK});
    end
    bus(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 8; i++) begin
      {lat_tx, lat_rts, tx_bit, cts_lvl} <= 4'($urandom());
      wr(MODE_REG_ADDR, {16'h0, i[2], 5'h0, i[1:0], 8'h0});
      wr(PIN_STATE_ADDR, 32'h3f);
      bus(1'b0, PIN_STATE_ADDR, 32'h0);
      chk(rd, i[2] ? {26'h0, 1'b1, exp_own(i[1:0])} : 32'h0);
      chk(tx_pin, i[2] ? tx_bit : lat_tx);
      chk(own, i[2] ? exp_own(i[1:0]) : 5'h0);
      if (!(i[2] && i[1:0] == 2'b11)) chk(rts_pin, i[2] && i[1:0] != 2'b00 ? rts_flow : lat_rts);
      chk(cts, i[2] && i[1:0] == 2'b10 ? cts_pin : 1'b0);
    end
    for (i = 0; i < 4; i++) begin
      {tx_busy, rts_flow} <= 2'($urandom());
      wr(MODE_REG_ADDR, {16'h0, 4'h8, i[0], 11'h100});
      chk(rts_pin, i[0] ? !tx_busy : rts_flow);
    end
    wr(MODE_REG_ADDR, 32'ha000);
    for (i = 0; i < 4; i++) begin
      idle <= i[0];
      if (i == 2) wr(MODE_REG_ADDR, 32'h8000);
      repeat (3) @(posedge clk);
      chk(run, !(i[0] && i < 2));
    end
    wr(MODE_REG_ADDR, 32'h8300);
    count(2, 80);
    chk(cnt, 80 / (div + 1));
    count(3, 80);
    chk(cnt, 80 / 2);
    for (i = 0; i < 4; i++) begin
      tx_bit <= i[0];
      wr(MODE_REG_ADDR, i[1] ? 32'h9000 : 32'h8000);
      count(0, 128);
      chk(cnt, i[1] ? (i[0] ? 0 : 2 * IR_PULSE_SIXTEENTHS * (div + 1)) : (i[0] ? 128 : 0));
      count(1, 128);
      chk(cnt > 0, !i[0]);
    end
    results();
  end
endmodule
`default_nettype wire
